// File: hdl/dswap_port.sv
// debug serial word access port with its write fifo
`timescale 1ns/1ps
// Notes on behaviour
// - select high resets transaction at once, no clocks needed
// - first eight bits are the command
// - next sixteen bits are start address
// - then sixteen bit data words follow
// - input sampled on serial clock rise
// - output changes on serial clock fall
// - each further word advances address by one
// - command 02 writes first data word
// - later write words go to next locations
// - command 03 reads the given address
// - read sends check word, then data
// - check word is command, address high byte
// - reads continue sequentially while selected
// - deselected output: 0 running, 1 stopped

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module dswap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // full and empty share one wrap-bit compare, so powers of two only
    localparam logic [AW:0] FILL_MAX = DEPTH[AW:0];
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dswap_fifo_st_t;
    dswap_fifo_st_t s_r, s_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic full, empty;

    assign empty = s_r.wp == s_r.rp;
    assign full = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[s_r.rp[AW-1:0]];

    always_comb begin
        s_nxt = s_r;
        if (in_valid && !full) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (in_valid && !full) begin
            mem_r[s_r.wp[AW-1:0]] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fifo_count: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.wp - s_r.rp <= FILL_MAX)
        else $error("fifo holds more than its depth");
    a_fifo_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head moved without a read");
endmodule : dswap_fifo

// ------------------------------------------------------------
// serial engine
// ------------------------------------------------------------
module dswap_port #(
    parameter int FIFO_D = dswap_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic spi_clk,
    input wire logic spi_sel_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic cpu_stopped,
    output logic wr_valid,
    input wire logic wr_ready,
    output dswap_pkg::dswap_wr_t wr_out,
    output dswap_pkg::dswap_rd_t rd_out,
    input wire logic [15:0] rd_data
);
    import dswap_pkg::*;

    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] sel_s;
        logic [1:0] mosi_s;
        logic clk_d;
        dswap_state_t st;
        logic [4:0] bits;
        logic [1:0] hicnt;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] sh_in;
        logic [15:0] sh_out;
        logic miso;
        dswap_rd_t rd;
    } dswap_st_t;

    dswap_st_t s_r, s_nxt;
    logic rise, fall, sel_n, mosi;
    logic fifo_in_valid, fifo_in_ready;
    dswap_wr_t fifo_in;
    dswap_wr_t fifo_out;
    logic fifo_out_valid;

    // pins are asynchronous; only the second stage feeds logic
    assign rise = s_r.clk_s[1] && !s_r.clk_d;
    assign fall = !s_r.clk_s[1] && s_r.clk_d;
    assign sel_n = s_r.sel_s[1];
    assign mosi = s_r.mosi_s[1];

    always_comb begin
        s_nxt = s_r;
        fifo_in_valid = 1'b0;
        fifo_in = '{addr: s_r.addr, data: {s_r.sh_in[14:0], mosi}};
        s_nxt.clk_s = {s_r.clk_s[0], spi_clk};
        s_nxt.sel_s = {s_r.sel_s[0], spi_sel_n};
        s_nxt.mosi_s = {s_r.mosi_s[0], spi_mosi};
        s_nxt.clk_d = s_r.clk_s[1];
        s_nxt.rd.req = 1'b0;
        if (sel_n) begin
            // deselected: idle level shows processor state
            s_nxt.miso = cpu_stopped;
            if (rise && s_r.hicnt != RSTCNT_MAX) begin
                s_nxt.hicnt = s_r.hicnt + 2'h1;
            end
            if (rise && s_r.hicnt + 2'h1 >= RSTCNT_MAX) begin
                s_nxt.st = DSWAP_IDLE;
            end
            if (s_r.st != DSWAP_IDLE) begin
                s_nxt.st = DSWAP_IDLE;
            end
            s_nxt.bits = BITCNT_RST;
        end else begin
            s_nxt.hicnt = 2'h0;
            if (s_r.st == DSWAP_IDLE) begin
                s_nxt.st = DSWAP_CMD;
                s_nxt.bits = BITCNT_RST;
            end
            if (rise && s_r.st != DSWAP_IDLE) begin
                // msb first on the way in
                s_nxt.sh_in = {s_r.sh_in[14:0], mosi};
                s_nxt.bits = s_r.bits + 5'h01;
                unique case (s_r.st)
                    DSWAP_CMD: begin
                        if (s_r.bits == 5'(CMD_W - 1)) begin
                            s_nxt.cmd = {s_r.sh_in[6:0], mosi};
                            s_nxt.st = DSWAP_ADDR;
                            s_nxt.bits = BITCNT_RST;
                        end
                    end
                    DSWAP_ADDR: begin
                        if (s_r.bits == 5'(WORD_W - 1)) begin
                            s_nxt.addr = {s_r.sh_in[14:0], mosi};
                            s_nxt.bits = BITCNT_RST;
                            if (s_r.cmd == CMD_WRITE) begin
                                s_nxt.st = DSWAP_WDATA;
                            end else if (s_r.cmd == CMD_READ) begin
                                s_nxt.st = DSWAP_RDATA;
                                // check word first, then memory data
                                s_nxt.sh_out = {s_r.cmd,
                                    s_r.sh_in[14:7]};
                                s_nxt.rd = '{req: 1'b1,
                                    addr: {s_r.sh_in[14:0], mosi}};
                            end else begin
                                s_nxt.st = DSWAP_IGNORE;
                            end
                        end
                    end
                    DSWAP_WDATA: begin
                        if (s_r.bits == 5'(WORD_W - 1)) begin
                            // a full fifo drops the word; depth covers bursts
                            fifo_in_valid = 1'b1;
                            s_nxt.addr = s_r.addr + 16'h0001;
                            s_nxt.bits = BITCNT_RST;
                        end
                    end
                    DSWAP_RDATA: begin
                        if (s_r.bits == 5'(WORD_W - 1)) begin
                            // fetch runs one word ahead of the shifter
                            s_nxt.bits = BITCNT_RST;
                            s_nxt.sh_out = rd_data;
                            s_nxt.addr = s_r.addr + 16'h0001;
                            s_nxt.rd = '{req: 1'b1,
                                addr: s_r.addr + 16'h0001};
                        end
                    end
                    DSWAP_IGNORE: begin
                        s_nxt.bits = BITCNT_RST;
                    end
                    default: begin
                        s_nxt.st = DSWAP_IDLE;
                    end
                endcase
            end
            if (fall && s_r.st == DSWAP_RDATA) begin
                // msb first, updated on falling edge
                s_nxt.miso = s_r.sh_out[15];
                s_nxt.sh_out = {s_r.sh_out[14:0], 1'b0};
            end else if (s_r.st != DSWAP_RDATA) begin
                s_nxt.miso = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.sel_s <= 2'h3;
            s_r.st <= DSWAP_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    dswap_fifo #(.WIDTH($bits(dswap_wr_t)), .DEPTH(FIFO_D)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(wr_ready || !wr_valid),
        .out_data(fifo_out)
    );

    // registered handoff keeps outputs flop driven
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_valid <= 1'b0;
            wr_out <= '0;
        end else if (wr_ready || !wr_valid) begin
            wr_valid <= fifo_out_valid;
            wr_out <= fifo_out;
        end
    end

    assign spi_miso = s_r.miso;
    assign rd_out = s_r.rd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_idle_level: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $past(sel_n) && sel_n && $past(sel_n, 2) && !$past(sys_rst)
            |-> spi_miso == $past(cpu_stopped))
        else $error("idle output level wrong");
    a_write_cmd: assert property (
        @(posedge mclk) disable iff (sys_rst)
        fifo_in_valid |-> s_r.cmd == CMD_WRITE
            && s_r.st == DSWAP_WDATA)
        else $error("write without write command");
    a_wr_no_read: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.st == DSWAP_WDATA |-> !s_r.rd.req)
        else $error("read request during a write");
    a_addr_step: assert property (
        @(posedge mclk) disable iff (sys_rst)
        fifo_in_valid |=> s_r.addr == $past(s_r.addr) + 16'h0001)
        else $error("address not advanced");
    a_wr_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_out))
        else $error("write request dropped before accept");
    a_rd_first: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.st == DSWAP_ADDR && s_nxt.st == DSWAP_RDATA
            |=> s_r.rd.req && s_r.rd.addr == s_r.addr)
        else $error("read not requested at its address");
    a_check_word: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.st == DSWAP_ADDR && s_nxt.st == DSWAP_RDATA
            |=> s_r.sh_out[15:8] == CMD_READ
            && s_r.sh_out[7:0] == s_r.addr[15:8])
        else $error("check word lacks command");
    // memory gets a whole serial word to answer each request
    a_rd_load: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !sel_n && rise && s_r.st == DSWAP_RDATA
            && s_r.bits == 5'(WORD_W - 1)
            |=> s_r.sh_out == $past(rd_data))
        else $error("read data not loaded at word end");
    a_rd_step: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $past(s_r.st) == DSWAP_RDATA && s_r.rd.req
            |-> s_r.rd.addr == $past(s_r.addr) + 16'h0001)
        else $error("burst read address not advanced");
    a_rd_pulse: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.rd.req |=> !s_r.rd.req)
        else $error("read request longer than one cycle");
    a_sel_reset: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sel_n && s_r.st != DSWAP_IDLE |=> s_r.st == DSWAP_IDLE)
        else $error("deselect did not reset");
    a_hi_clear: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !sel_n |=> s_r.hicnt == 2'h0)
        else $error("reset count kept while selected");
    a_miso_fall: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !sel_n && s_r.st == DSWAP_RDATA && !fall
            |=> $stable(spi_miso))
        else $error("output moved off falling edge");
    a_ignore_cmd: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.st == DSWAP_IGNORE |-> !fifo_in_valid && !s_r.rd.req)
        else $error("access on unknown command");
    a_cmd_bits: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.st == DSWAP_CMD |-> s_r.bits < 5'(CMD_W))
        else $error("command longer than eight bits");
    a_word_bits: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_r.bits < 5'(WORD_W))
        else $error("word longer than sixteen bits");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_write: cover property (@(posedge mclk) fifo_in_valid);
    c_read: cover property (@(posedge mclk) s_r.rd.req);
    c_ignore: cover property (@(posedge mclk) s_r.st == DSWAP_IGNORE);
    // a stalled sink overflows the fifo; that word is lost
    c_drop: cover property (@(posedge mclk) fifo_in_valid && !fifo_in_ready);
    c_burst_read: cover property (@(posedge mclk)
        s_r.rd.req && $past(s_r.st) == DSWAP_RDATA);
endmodule : dswap_port

// File: hdl/dswap_pkg.sv
// shared constants and types of the debug serial word access port
package dswap_pkg;
    localparam int CMD_W = 8;
    localparam int WORD_W = 16;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [4:0] BITCNT_RST = 5'h00;
    localparam logic [1:0] RSTCNT_MAX = 2'h2;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        DSWAP_IDLE = 3'b000,
        DSWAP_CMD = 3'b001,
        DSWAP_ADDR = 3'b011,
        DSWAP_WDATA = 3'b010,
        DSWAP_RDATA = 3'b110,
        DSWAP_IGNORE = 3'b111
    } dswap_state_t;

    // write request toward the device memory
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } dswap_wr_t;

    // read request: strobe and address
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } dswap_rd_t;
endpackage : dswap_pkg

// File: tb/dswap_master.sv
// debug master model that drives the serial lines
`timescale 1ns/1ps
module dswap_master (
    output logic spi_clk,
    output logic spi_sel_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    logic [15:0] rx_q[$];
    initial begin
        spi_clk = 1'b0;
        spi_sel_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic shift(input logic [15:0] v, input int n,
            output logic [15:0] r);
        for (int i = n - 1; i >= 0; i--) begin
            spi_mosi = v[i];
            #40 spi_clk = 1'b1;
            r = {r[14:0], spi_miso};
            #40 spi_clk = 1'b0;
        end
    endtask : shift
    // ------------------------------------------------------------
    // one frame; two clocks with select high come before each frame
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] cmd, input logic [15:0] addr,
            input logic [15:0] wd[$], input int extra);
        logic [15:0] r;
        rx_q = {};
        spi_sel_n = 1'b1;
        shift(16'h0000, 2, r);
        spi_sel_n = 1'b0;
        #40;
        shift({8'h00, cmd}, 8, r);
        shift(addr, 16, r);
        foreach (wd[i]) begin
            shift(wd[i], 16, r);
            rx_q.push_back(r);
        end
        shift(16'h0000, extra, r);
        #40 spi_sel_n = 1'b1;
        // released line: inverse of last bit, not a stale copy
        spi_mosi = ~spi_mosi;
    endtask : frame
endmodule : dswap_master

// File: tb/test_dswap_port.sv
// self-checking bench of the debug serial word access port
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_dswap_port;
    import dswap_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_clk;
    logic spi_sel_n;
    logic spi_mosi;
    logic spi_miso;
    logic cpu_stopped = 1'b0;
    logic wr_valid;
    logic wr_ready = 1'b0;
    dswap_wr_t wr_out;
    dswap_rd_t rd_out;
    logic [15:0] rd_data = 16'h0000;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int rmode = 0; // 0 stall, 1 random, 2 ready
    logic [15:0] lf = 16'h4983;
    logic [15:0] mem[int];
    dswap_wr_t exp_w[$];
    dswap_wr_t exp_head;
    logic [7:0] odd_cmd[4] = '{8'h00, 8'h01, 8'h04, 8'h83};
    always #5 mclk = ~mclk;
    dswap_port #(.FIFO_D(8)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .cpu_stopped(cpu_stopped),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_out(wr_out),
        .rd_out(rd_out), .rd_data(rd_data));
    // miso goes to this one master only; it is never released
    dswap_master m (.spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd
    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : a ^ 16'h5A3C;
    endfunction : peek
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // memory side: write sink, read answer, timeout
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wr_valid === 1'b1 && wr_ready) begin
            if (exp_w.size() == 0) begin
                `CHK(wr_valid, 1'b0)
            end else begin
                exp_head = exp_w.pop_front();
                `CHK(wr_out, exp_head)
            end
        end
        if (rd_out.req === 1'b1) begin
            rd_data <= #1 peek(rd_out.addr);
        end
        wr_ready <= #1 rmode == 2 || (rmode == 1 && rnd() > 16'h7FFF);
        if (cyc > 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic wr_frame(input logic [15:0] a, input int n, int keep,
            int extra);
        logic [15:0] w[$];
        for (int i = 0; i < n; i++) begin
            w.push_back(rnd());
            if (i < keep) begin
                exp_w.push_back({a + i[15:0], w[i]});
                mem[int'(a + i[15:0])] = w[i];
            end
        end
        m.frame(CMD_WRITE, a, w, extra);
    endtask : wr_frame
    task automatic drain();
        for (int k = 0; k < 600 && exp_w.size() > 0; k++) @(posedge mclk);
        `CHK(exp_w.size(), 0)
    endtask : drain
    initial begin
        logic [15:0] w[$];
        logic [15:0] a;
        int n;
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            #1 cpu_stopped = s[0];
            repeat (5) @(posedge mclk);
            `CHK(spi_miso, s[0])
        end
        $display("idle level test done");
        // fifo fill: stalled sink keeps eight plus one in the output stage
        a = rnd();
        wr_frame(a, 10, 9, 0);
        rmode = 2;
        drain();
        `CHK(spi_miso, 1'b1)
        $display("fifo fill test done");
        rmode = 1;
        for (int t = 0; t < 4; t++) begin
            a = (t == 0) ? 16'hFFFE : rnd();
            n = t + 1 + (t == 0);
            wr_frame(a, n, n, int'(rnd() % 16));
            drain();
            w = {};
            for (int i = 0; i <= n; i++) w.push_back(rnd());
            m.frame(odd_cmd[t], a ^ 16'h00F0, w, 0);
            m.frame(CMD_READ, a, w, 0);
            `CHK(m.rx_q[0], {CMD_READ, a[15:8]})
            for (int i = 1; i <= n; i++) begin
                `CHK(m.rx_q[i], peek(a + i[15:0] - 16'h0001))
            end
            drain();
            $display("burst test %0d done", t);
        end
        tally_and_finish();
    end
endmodule : test_dswap_port
